/* File: bench/testbench.sv */
// Self-checking bench for the endpoint status block.
// Assumes the host model drives the engine side.
`timescale 1ns/10ps
`include "usb_ep_consts.vh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin fail_count++; $display("Error %s exp %h got %h", n, e, g); end end
module testbench;
reg core_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, nak, stl, zl;
reg [7:0] reg_addr = 0, reg_wdata = 0, d;
wire [7:0] reg_rdata, sie_rbyte, sie_wbyte;
wire [3:0] tok_ep;
wire [6:0] ep_irq;
wire setup_ok, out_ok, out_bank, out_crc_err, in_sent, in_acked, stall_sent, sie_push, sie_pop;
wire out_nak, halt_out, in_armed, in_zero_len;
int fail_count, compares, en, st[7];
int kd[7] = '{0, 2, 1, 3, 2, 1, 3};
logic [7:0] q[7][$];
logic [31:0] seed = 32'h0eef;
always #10 core_clk = ~core_clk;
usb_endpoint_status_fifo DUT (.*);
usb_host_model host (.*);
function logic [7:0] rnd();
   seed ^= seed << 13;
   seed ^= seed >> 17;
   seed ^= seed << 5;
   return seed[7:0];
endfunction
task give_verdict;
   if (fail_count == 0 && compares > 0) $display("STATUS OK");
   else $display("STATUS NOT OK");
   $finish;
endtask
task wr(input [7:0] a, v);
   @(posedge core_clk);
   {reg_addr, reg_wdata, reg_wr} <= {a, v, 1'b1};
   @(posedge core_clk);
   reg_wr <= 1'b0;
endtask
task rd(input [7:0] a);
   @(posedge core_clk);
   {reg_addr, reg_rd} <= {a, 1'b1};
   @(posedge core_clk);
   reg_rd <= 1'b0;
   #1 d = reg_rdata;
endtask
task chk(input int e);
   int m;
   wr(`OFS_EP_SELECT, 8'(e));
   rd(`OFS_EP_STATUS);
   `CHK("status", st[e][7:0], d)
   m = 0;
   for (int i = 0; i < 7; i++) m |= ((st[i] & (kd[i] == 1 ? 8'h47 : 8'h4f)) != 0) << i;
   rd(`OFS_EP_IRQ_FLAGS);
   `CHK("irq", 8'(m & en), d)
   `CHK("ep_irq", 7'(m & en), ep_irq)
endtask
task fw(input int e, s, c);
   st[e] = (st[e] | s) & ~c;
   wr(`OFS_EP_SELECT, 8'(e));
   wr(`OFS_EP_STATUS, 8'((st[e] & 8'hb0) | (8'h4f & ~c)));
   chk(e);
endtask
task fifo(input int e, push);
   wr(`OFS_EP_SELECT, 8'(e));
   d = rnd();
   if (push) q[e].push_back(d);
   if (push) wr(`OFS_EP_FIFO, d);
   else rd(`OFS_EP_FIFO);
   if (!push) `CHK("fifo", q[e].pop_front(), d)
endtask
task out_t(input int e, b, c);
   int m;
   logic [7:0] v;
   v = rnd();
   m = (e > 3 && b) ? 8'h40 : 8'h02;
   host.out_pkt(e, b, c, v, nak, stl);
   `CHK("stall", st[e][5], stl)
   `CHK("nak", kd[e] != 1 && (st[e] & m) != 0, nak)
   if (stl) st[e] |= 8;
   else if (!nak) begin
      q[e].push_back(v);
      st[e] = kd[e] == 1 ? st[e] & ~8 | m | c << 3 : st[e] | m;
   end
   chk(e);
endtask
task in_t(input int e, ack);
   logic [7:0] v;
   host.in_pkt(e, ack, zl, v);
   `CHK("zlp", st[e][4] && q[e].size() == 0, zl)
   if (st[e][4] && q[e].size() > 0) begin
      d = q[e].pop_front();
      `CHK("in", d, v)
   end
   if (st[e][4] && (ack || kd[e] == 1)) st[e] = st[e] & ~16 | 1;
   chk(e);
endtask
initial begin
   #400000;
   fail_count++;
   give_verdict();
end
initial begin
   repeat (20) @(posedge core_clk);
   rst_n <= 1'b1;
   en = rnd() & 8'h7f;
   wr(`OFS_EP_IRQ_EN, 8'(en));
   for (int e = 0; e < 7; e++) begin
      wr(`OFS_EP_SELECT, 8'(e));
      wr(`OFS_EP_CONFIG, 8'(kd[e]));
      rd(`OFS_EP_CONFIG);
      `CHK("kind", 8'(kd[e]), d)
      chk(e);
   end
   out_t(1, 0, 0);
   out_t(1, 0, 0);
   out_t(4, 1, 0);
   out_t(4, 1, 0);
   out_t(5, 0, 1);
   out_t(5, 0, 0);
   fifo(1, 0);
   fw(1, 0, 2);
   fw(1, 32, 0);
   out_t(1, 0, 0);
   fw(1, 0, 40);
   fifo(3, 1);
   fw(3, 16, 0);
   in_t(3, 0);
   in_t(3, 1);
   fw(3, 0, 1);
   fw(5, 16, 0);
   in_t(5, 0);
   out_t(0, 0, 0);
   fw(0, 32, 0);
   host.setup_pkt(0, 8'h5a);
   q[0].push_back(8'h5a);
   st[0] = 4;
   chk(0);
   fw(0, 128, 0);
   fw(0, 0, 128);
   fifo(0, 0);
   fifo(0, 0);
   fw(0, 0, 4);
   give_verdict();
end
endmodule

/* File: bench/usb_ep_sva.sv */
// Port checker for the endpoint status block.
// Assumes one core_clk domain; tracks select, kind and enable writes.
`timescale 1ns/10ps
`include "usb_ep_consts.vh"
module usb_ep_sva #(
   parameter NEP = 7
) (
   input wire core_clk,
   input wire rst_n,
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire [3:0] tok_ep,
   input wire setup_ok,
   input wire out_ok,
   input wire out_bank,
   input wire in_sent,
   input wire in_acked,
   input wire out_nak,
   input wire halt_out,
   input wire in_armed,
   input wire in_zero_len,
   input wire [NEP-1:0] ep_irq
);
reg [3:0] sel_r;
reg [NEP-1:0] en_r;
reg [1:0] kind_r [0:15];
integer i;
wire lv = tok_ep < 4'h7;
wire iso = kind_r[tok_ep] == `KIND_ISO;
default clocking @(posedge core_clk); endclocking
default disable iff (!rst_n);
always @(posedge core_clk or negedge rst_n) begin
   if (!rst_n) begin
      sel_r <= `RST_SELECT;
      en_r <= {NEP{1'b0}};
      for (i = 0; i < 16; i = i + 1) kind_r[i] <= `RST_KIND;
   end else if (reg_wr) begin
      if (reg_addr == `OFS_EP_SELECT) sel_r <= reg_wdata[3:0];
      if (reg_addr == `OFS_EP_IRQ_EN) en_r <= reg_wdata[NEP-1:0];
      if (reg_addr == `OFS_EP_CONFIG && sel_r < 4'h7) kind_r[sel_r] <= reg_wdata[1:0];
   end
end
property p_rx0; out_ok && lv && !out_bank && !iso ##1 $stable(tok_ep) && !out_bank |-> out_nak; endproperty
a_rx0: assert property (p_rx0) else $error("bank 0 not refused");
property p_rx1; out_ok && lv && out_bank && tok_ep > 3 && !iso ##1 $stable(tok_ep) && out_bank |-> out_nak; endproperty
a_rx1: assert property (p_rx1) else $error("bank 1 not refused");
property p_iso; lv && iso |-> !out_nak; endproperty
a_iso: assert property (p_iso) else $error("iso refused");
property p_setup; setup_ok && lv ##1 $stable(tok_ep) |-> !in_armed && !out_nak; endproperty
a_setup: assert property (p_setup) else $error("setup left flags");
property p_halt; setup_ok && lv && kind_r[tok_ep] == `KIND_CTRL ##1 $stable(tok_ep) |-> !halt_out; endproperty
a_halt: assert property (p_halt) else $error("halt kept on setup");
property p_done; in_armed && in_sent && in_acked && !reg_wr ##1 $stable(tok_ep) |-> !in_armed; endproperty
a_done: assert property (p_done) else $error("ready not cleared");
property p_zlp; in_zero_len |-> in_armed; endproperty
a_zlp: assert property (p_zlp) else $error("zero length unarmed");
property p_mask; (ep_irq & ~en_r) == {NEP{1'b0}}; endproperty
a_mask: assert property (p_mask) else $error("masked irq");
property p_evt; out_ok && lv ##1 $stable(tok_ep) |-> ep_irq[tok_ep] == en_r[tok_ep]; endproperty
a_evt: assert property (p_evt) else $error("no receive irq");
c_setup: cover property (setup_ok && lv);
c_nak: cover property (out_nak);
c_zlp: cover property (in_zero_len && in_sent);
endmodule
bind usb_endpoint_status_fifo usb_ep_sva #(.NEP(NEP)) chk (.*);

/* File: bench/usb_host_model.sv */
// Host side model driving the engine event ports.
// Assumes the bench calls one task at a time.
`timescale 1ns/10ps
module usb_host_model (
   input wire core_clk,
   input wire out_nak,
   input wire halt_out,
   input wire in_armed,
   input wire in_zero_len,
   input wire [7:0] sie_rbyte,
   output reg [3:0] tok_ep,
   output reg setup_ok, out_ok, out_bank, out_crc_err, in_sent, in_acked, stall_sent, sie_push, sie_pop,
   output reg [7:0] sie_wbyte
);
initial {tok_ep, setup_ok, out_ok, out_bank, out_crc_err, in_sent, in_acked, stall_sent, sie_push, sie_pop, sie_wbyte} = 0;
task automatic tx(input int e, input b);
   @(posedge core_clk);
   tok_ep <= 4'(e);
   out_bank <= b;
   @(posedge core_clk);
   #1;
endtask
task automatic out_pkt(input int e, input b, c, input [7:0] v, output nak, stl);
   tx(e, b);
   nak = out_nak;
   stl = halt_out;
   @(posedge core_clk);
   stall_sent <= stl;
   sie_push <= !nak && !stl;
   sie_wbyte <= v;
   @(posedge core_clk);
   {stall_sent, sie_push} <= 2'b00;
   out_ok <= !nak && !stl;
   out_crc_err <= c;
   @(posedge core_clk);
   out_ok <= 1'b0;
endtask
task automatic in_pkt(input int e, input ack, output zl, output [7:0] v);
   reg a;
   tx(e, 1'b0);
   a = in_armed && !halt_out;
   zl = in_zero_len;
   @(posedge core_clk);
   stall_sent <= halt_out;
   sie_pop <= a && !zl;
   @(posedge core_clk);
   {stall_sent, sie_pop} <= 2'b00;
   in_sent <= a;
   in_acked <= a && ack;
   @(posedge core_clk);
   {in_sent, in_acked} <= 2'b00;
   #1 v = sie_rbyte;
endtask
task automatic setup_pkt(input int e, input [7:0] v);
   tx(e, 1'b0);
   @(posedge core_clk);
   sie_push <= 1'b1;
   sie_wbyte <= v;
   @(posedge core_clk);
   sie_push <= 1'b0;
   setup_ok <= 1'b1;
   @(posedge core_clk);
   setup_ok <= 1'b0;
endtask
endmodule

/* File: include/usb_ep_consts.vh */
// Constants for the endpoint status and FIFO data block.
// Included by the design file; holds definitions only.
`ifndef USB_EP_CONSTS_VH
`define USB_EP_CONSTS_VH

// Register offsets
`define OFS_EP_SELECT 8'hc7
`define OFS_EP_STATUS 8'hce
`define OFS_EP_FIFO 8'hcf
`define OFS_EP_CONFIG 8'hd4
`define OFS_EP_IRQ_EN 8'hf3
`define OFS_EP_IRQ_FLAGS 8'hf8

// Status bit positions
`define ST_DIR 7
`define ST_RX1 6
`define ST_HALT 5
`define ST_TRANSMIT_READY 4
`define ST_HALT_SENT_OR_CHECKSUM_ERROR 3
`define ST_SETUP 2
`define ST_RX0 1
`define ST_TRANSMIT_COMPLETE 0

// Endpoint kinds
`define KIND_CTRL 2'h0
`define KIND_ISO 2'h1
`define KIND_BULK 2'h2
`define KIND_INTR 2'h3

// Reset values and the SETUP status load value
`define RST_STATUS 8'h00
`define RST_SELECT 4'h0
`define RST_KIND 2'h0
`define RST_BYTE 8'h00
`define SETUP_ONLY 8'h04

// Field widths
`define SEL_W 4
`define KIND_W 2

`endif

/* File: logic/usb_endpoint_status_fifo.v */
// Endpoint status flags and per-endpoint FIFO for a full-speed USB function.
// Assumes a serial engine on core_clk giving one-cycle event pulses and a
// firmware port with one-cycle strobes and read data one cycle later.
//
// Contract
// - Ping-pong endpoints set bank-1 received flag when bank 1 is filled.
// - While bank-1 flag set, OUT to bank 1 gets NAK, except isochronous.
// - Halt request set by firmware makes the device answer STALL.
// - Control endpoints clear halt request on a valid SETUP.
// - Transmit ready with an empty FIFO sends a zero-length packet.
// - Transmit ready cleared on send (iso) or on host ACK (others).
// - Non-iso endpoints flag a sent STALL; firmware clears the flag.
// - Iso endpoints show a read-only checksum error per received packet.
// - Valid SETUP sets setup flag and clears all other status bits, except halt on non-control endpoints.
// - Bank-0 received flag set on store; NAKs bank 0 except iso.
// - Control endpoints take an early SETUP even with bank-0 flag set.
// - Transmit complete set on send (iso) or on host ACK (others).
// - FIFO data register pushes and pops bytes of the selected endpoint.
// - Kind 00 control, 01 iso, 10 bulk, 11 interrupt steers flags.
`timescale 1ns/10ps
`include "usb_ep_consts.vh"

module usb_endpoint_status_fifo #(
   parameter NEP = 7,
   parameter EW = 3,
   parameter AW = 5,
   parameter PP_FIRST = 4
) (
   input wire core_clk,
   input wire rst_n,
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [7:0] reg_rdata,
   input wire [3:0] tok_ep,
   input wire setup_ok,
   input wire out_ok,
   input wire out_bank,
   input wire out_crc_err,
   input wire in_sent,
   input wire in_acked,
   input wire stall_sent,
   input wire sie_push,
   input wire [7:0] sie_wbyte,
   input wire sie_pop,
   output reg [7:0] sie_rbyte,
   output wire out_nak,
   output wire halt_out,
   output wire in_armed,
   output wire in_zero_len,
   output wire [NEP-1:0] ep_irq
);

   localparam PW = AW + 1;
   localparam DEPTH = 1 << AW;

   reg [`SEL_W-1:0] sel_r;
   reg [NEP-1:0] ien_r;
   reg [7:0] mem [0:NEP*DEPTH-1];

   wire [8*NEP-1:0] st_all;
   wire [`KIND_W*NEP-1:0] kind_all;
   wire [PW*NEP-1:0] wp_all;
   wire [PW*NEP-1:0] rp_all;

   wire tok_ok = (tok_ep < NEP);
   wire sel_ok = (sel_r < NEP);
   wire [EW-1:0] tok_i = tok_ep[EW-1:0];
   wire [EW-1:0] sel_i = sel_r[EW-1:0];

   wire wr_sta = reg_wr && (reg_addr == `OFS_EP_STATUS);
   wire wr_fifo = reg_wr && (reg_addr == `OFS_EP_FIFO);
   wire rd_fifo = reg_rd && (reg_addr == `OFS_EP_FIFO);
   wire wr_cfg = reg_wr && (reg_addr == `OFS_EP_CONFIG);

   // Serial engine owns the FIFO port when both sides move at once
   wire sie_wr_go = sie_push && tok_ok;
   wire sie_rd_go = sie_pop && tok_ok;
   wire fw_wr_go = wr_fifo && sel_ok && !sie_wr_go;
   wire fw_rd_go = rd_fifo && sel_ok && !sie_rd_go;

   genvar i;
   generate
      for (i = 0; i < NEP; i = i + 1) begin : ep
         reg [7:0] st_r;
         reg [7:0] st_nxt;
         reg [`KIND_W-1:0] kind_r;
         reg [PW-1:0] wp_r;
         reg [PW-1:0] rp_r;
         wire sel = sel_ok && (sel_i == i);
         wire tok = tok_ok && (tok_i == i);
         wire iso = (kind_r == `KIND_ISO);
         wire ctl = (kind_r == `KIND_CTRL);
         wire pp = (i >= PP_FIRST);
         wire bank1 = pp && out_bank;
         wire in_done = iso ? in_sent : in_acked;

         always @* begin
            st_nxt = st_r;
            if (wr_sta && sel) begin
               st_nxt[`ST_DIR] = reg_wdata[`ST_DIR];
               st_nxt[`ST_HALT] = reg_wdata[`ST_HALT];
               st_nxt[`ST_TRANSMIT_READY] = reg_wdata[`ST_TRANSMIT_READY];
               st_nxt[`ST_RX1] = st_r[`ST_RX1] & reg_wdata[`ST_RX1];
               st_nxt[`ST_RX0] = st_r[`ST_RX0] & reg_wdata[`ST_RX0];
               st_nxt[`ST_SETUP] = st_r[`ST_SETUP] & reg_wdata[`ST_SETUP];
               st_nxt[`ST_TRANSMIT_COMPLETE] = st_r[`ST_TRANSMIT_COMPLETE] & reg_wdata[`ST_TRANSMIT_COMPLETE];
               if (!iso) begin
                  st_nxt[`ST_HALT_SENT_OR_CHECKSUM_ERROR] = st_r[`ST_HALT_SENT_OR_CHECKSUM_ERROR] & reg_wdata[`ST_HALT_SENT_OR_CHECKSUM_ERROR];
               end
            end
            if (tok && out_ok) begin
               if (iso) begin
                  st_nxt[`ST_HALT_SENT_OR_CHECKSUM_ERROR] = out_crc_err;
               end
               if (bank1) begin
                  st_nxt[`ST_RX1] = 1'b1;
               end else begin
                  st_nxt[`ST_RX0] = 1'b1;
               end
            end
            if (tok && in_done) begin
               st_nxt[`ST_TRANSMIT_READY] = 1'b0;
               st_nxt[`ST_TRANSMIT_COMPLETE] = 1'b1;
            end
            if (tok && stall_sent && !iso) begin
               st_nxt[`ST_HALT_SENT_OR_CHECKSUM_ERROR] = 1'b1;
            end
            if (tok && setup_ok) begin
               st_nxt = `SETUP_ONLY;
               if (!ctl) begin
                  st_nxt[`ST_HALT] = st_r[`ST_HALT];
               end
            end
         end

         always @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
               st_r <= `RST_STATUS;
               kind_r <= `RST_KIND;
               wp_r <= {PW{1'b0}};
               rp_r <= {PW{1'b0}};
            end else begin
               st_r <= st_nxt;
               if (wr_cfg && sel) begin
                  kind_r <= reg_wdata[`KIND_W-1:0];
               end
               if ((sie_wr_go && tok) || (fw_wr_go && sel)) begin
                  wp_r <= wp_r + 1'b1;
               end
               if ((sie_rd_go && tok) || (fw_rd_go && sel)) begin
                  rp_r <= rp_r + 1'b1;
               end
            end
         end

         assign st_all[8*i +: 8] = st_r;
         assign kind_all[`KIND_W*i +: `KIND_W] = kind_r;
         assign wp_all[PW*i +: PW] = wp_r;
         assign rp_all[PW*i +: PW] = rp_r;
         assign ep_irq[i] = ien_r[i] & (st_r[`ST_RX1] | st_r[`ST_RX0] | st_r[`ST_SETUP] |
                            st_r[`ST_TRANSMIT_COMPLETE] | (st_r[`ST_HALT_SENT_OR_CHECKSUM_ERROR] & !iso));
      end
   endgenerate

   wire [7:0] tok_st = tok_ok ? st_all[8*tok_i +: 8] : `RST_STATUS;
   wire [7:0] sel_st = sel_ok ? st_all[8*sel_i +: 8] : `RST_STATUS;
   wire [`KIND_W-1:0] tok_kind = kind_all[`KIND_W*tok_i +: `KIND_W];
   wire [`KIND_W-1:0] sel_kind = sel_ok ? kind_all[`KIND_W*sel_i +: `KIND_W] : `RST_KIND;
   wire [PW-1:0] tok_wp = wp_all[PW*tok_i +: PW];
   wire [PW-1:0] tok_rp = rp_all[PW*tok_i +: PW];
   wire [PW-1:0] sel_wp = wp_all[PW*sel_i +: PW];
   wire [PW-1:0] sel_rp = rp_all[PW*sel_i +: PW];
   wire tok_iso = (tok_kind == `KIND_ISO);
   wire tok_bank1 = (tok_ep >= PP_FIRST) && out_bank;

   assign out_nak = tok_ok && !tok_iso && (tok_bank1 ? tok_st[`ST_RX1] : tok_st[`ST_RX0]);
   assign halt_out = tok_st[`ST_HALT];
   assign in_armed = tok_st[`ST_TRANSMIT_READY];
   assign in_zero_len = tok_st[`ST_TRANSMIT_READY] && (tok_wp == tok_rp);

   wire [EW+AW-1:0] waddr = sie_wr_go ? {tok_i, tok_wp[AW-1:0]} : {sel_i, sel_wp[AW-1:0]};
   wire [EW+AW-1:0] sie_raddr = {tok_i, tok_rp[AW-1:0]};
   wire [EW+AW-1:0] fw_raddr = {sel_i, sel_rp[AW-1:0]};

   always @(posedge core_clk) begin
      if (sie_wr_go) begin
         mem[waddr] <= sie_wbyte;
      end else if (fw_wr_go) begin
         mem[waddr] <= reg_wdata;
      end
   end

   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sel_r <= `RST_SELECT;
         ien_r <= {NEP{1'b0}};
         sie_rbyte <= `RST_BYTE;
      end else begin
         if (reg_wr && (reg_addr == `OFS_EP_SELECT)) begin
            sel_r <= reg_wdata[`SEL_W-1:0];
         end
         if (reg_wr && (reg_addr == `OFS_EP_IRQ_EN)) begin
            ien_r <= reg_wdata[NEP-1:0];
         end
         if (sie_rd_go) begin
            sie_rbyte <= mem[sie_raddr];
         end
      end
   end

   // Register read mux
   reg [7:0] rd_nxt;
   always @* begin
      rd_nxt = `RST_BYTE;
      case (reg_addr)
         `OFS_EP_SELECT: rd_nxt = {{(8-`SEL_W){1'b0}}, sel_r};
         `OFS_EP_STATUS: rd_nxt = sel_st;
         `OFS_EP_FIFO: rd_nxt = fw_rd_go ? mem[fw_raddr] : `RST_BYTE;
         `OFS_EP_CONFIG: rd_nxt = {{(8-`KIND_W){1'b0}}, sel_kind};
         `OFS_EP_IRQ_EN: rd_nxt = {{(8-NEP){1'b0}}, ien_r};
         `OFS_EP_IRQ_FLAGS: rd_nxt = {{(8-NEP){1'b0}}, ep_irq};
         default: rd_nxt = `RST_BYTE;
      endcase
   end

   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= `RST_BYTE;
      end else if (reg_rd) begin
         reg_rdata <= rd_nxt;
      end else begin
         reg_rdata <= `RST_BYTE;
      end
   end

endmodule
